//--- rtl/tfp_cfg.svh
// constants for the timer flag, prescaler and periodic interrupt block
// Notes on behaviour
// - flags clear only by writing one
// - compare match sets its compare flag
// - shared flag follows selected capture/compare function
// - capture edge sets its capture flag
// - first flags pair with first masks
// - upper four masks gate second flags
// - counter wrap sets overflow flag
// - overflow enable gates overflow interrupt
// - prescale codes divide by 1,4,8,16
// - prescale written once within 64 cycles
// - second flag bits 3..0 read zero
// - second mask bits 3..2 read zero
// - periodic clock E/2^13, rate divides further
// - periodic chain runs free, reset only
// - period timed from free chain bits, not from previous timeout
// - timeout sets periodic flag, enable gates irq
// - full period before first periodic flag
// - writing bit 6 clears periodic flag
// - accumulator rollover sets bit 5 flag
// - accumulator edge sets bit 4 flag
`ifndef TFP_CFG_SVH
`define TFP_CFG_SVH
`define TFP_ADDR_FLG1     12'h000
`define TFP_ADDR_MSK1     12'h004
`define TFP_ADDR_MSK2     12'h008
`define TFP_ADDR_FLG2     12'h00c
`define TFP_ADDR_ACCUMULATOR_PERIODIC_CONTROL    12'h010
`define TFP_ADDR_CNT      12'h014
`define TFP_FLG2_MASK     8'hf0
`define TFP_MSK2_MASK     8'hf3
`define TFP_BIT_OVF       7
`define TFP_BIT_RTI       6
`define TFP_BIT_PAOV      5
`define TFP_BIT_PAI       4
`define TFP_BIT_SEL       2
`define TFP_PR_LO         0
`define TFP_RTR_LO        0
`define TFP_PR_WINDOW     7'h40
`define TFP_RTI_BASE_BITS 13
`define TFP_RTI_CNT_W     16
`endif

//--- rtl/tfp_pkg.sv
// types for the timer flag, prescaler and periodic interrupt block
package tfp_pkg;
  typedef struct packed {
    logic [7:0]  flg1;
    logic [7:0]  msk1;
    logic [7:0]  msk2;
    logic [7:0]  flg2;
    logic [7:0]  accumulator_periodic_control;
    logic [15:0] cnt;
    logic [3:0]  pre;
    logic [6:0]  age;
    logic        pr_done;
    logic [15:0] rti;
    logic        irq;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tfp_state_t;
  typedef struct packed {
    logic [4:0] cmp_match;
    logic [2:0] cap_edge;
    logic       cap4_edge;
    logic       acc_roll;
    logic       acc_edge;
  } tfp_events_t;
endpackage

//--- rtl/tfp_timer_flags.sv
// flag, mask, prescaler and periodic interrupt logic with apb registers
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "tfp_cfg.svh"
module tfp_timer_flags
  import tfp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire tfp_events_t events_i,
  input  wire logic        normal_mode_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             irq_o,
  output logic [15:0]      counter_o,
  output logic             capture_compare_select_o
);
  tfp_state_t s;
  tfp_state_t next_s;
  logic       acc;
  logic       wr;
  logic [7:0] wd;
  logic [7:0] set1;
  logic [7:0] set2;
  logic       tick;
  logic       rti_to;
  logic [15:0] rti_mask;

  assign acc = psel_i && penable_i && !s.pready;
  assign wr  = acc && pwrite_i;
  assign wd  = pwdata_i[7:0];

  // prescaler tick: codes divide by 1, 4, 8, 16
  always_comb
  begin
    unique case (s.msk2[`TFP_PR_LO +: 2])
      2'b00: tick = 1'b1;
      2'b01: tick = (s.pre[1:0] == 2'h3);
      2'b10: tick = (s.pre[2:0] == 3'h7);
      2'b11: tick = (s.pre == 4'hf);
    endcase
  end

  // periodic timeout mask: E/2^13 divided by 1, 2, 4 or 8
  always_comb
  begin
    rti_mask = 16'((32'h1 << (`TFP_RTI_BASE_BITS + 32'(s.accumulator_periodic_control[`TFP_RTR_LO +: 2]))) - 1);
  end
  // timed from the low bits of the free chain, not from the previous timeout
  assign rti_to = ((s.rti & rti_mask) == rti_mask);

  // event set vectors
  always_comb
  begin
    set1 = {s.flg1[7:0] & 8'h00};
    set1[7:3] = events_i.cmp_match;
    set1[2:0] = events_i.cap_edge;
    // shared flag follows the selected function
    set1[`TFP_BIT_SEL + 1] = s.accumulator_periodic_control[`TFP_BIT_SEL] ? events_i.cap4_edge
                                                    : events_i.cmp_match[0];
    set1[7:4] = events_i.cmp_match[4:1];
    set2 = 8'h00;
    set2[`TFP_BIT_OVF]  = tick && (s.cnt == 16'hffff);
    set2[`TFP_BIT_RTI]  = rti_to;
    set2[`TFP_BIT_PAOV] = events_i.acc_roll;
    set2[`TFP_BIT_PAI]  = events_i.acc_edge;
  end

  // next state
  always_comb
  begin
    next_s = s;
    next_s.pready  = acc;
    next_s.pslverr = 1'b0;
    next_s.rti = s.rti + 16'h1; // free running, reset only
    next_s.pre = s.pre + 4'h1;
    if (tick)
      next_s.cnt = s.cnt + 16'h1;
    if (s.age != `TFP_PR_WINDOW)
      next_s.age = s.age + 7'h1;
    // write one clears, set wins
    next_s.flg1 = (s.flg1 & ~(wr && paddr_i == `TFP_ADDR_FLG1 ? wd : 8'h00)) | set1;
    next_s.flg2 = ((s.flg2 & ~(wr && paddr_i == `TFP_ADDR_FLG2 ? wd : 8'h00)) | set2)
                  & `TFP_FLG2_MASK;
    if (wr)
    begin
      unique case (paddr_i)
        `TFP_ADDR_MSK1: next_s.msk1 = wd;
        `TFP_ADDR_MSK2:
        begin
          next_s.msk2[7:4] = wd[7:4];
          // single early write in normal modes
          if (!normal_mode_i || (!s.pr_done && s.age != `TFP_PR_WINDOW))
          begin
            next_s.msk2[`TFP_PR_LO +: 2] = wd[`TFP_PR_LO +: 2];
            next_s.pr_done = normal_mode_i;
          end
        end
        `TFP_ADDR_ACCUMULATOR_PERIODIC_CONTROL: next_s.accumulator_periodic_control = wd;
        `TFP_ADDR_FLG1, `TFP_ADDR_FLG2, `TFP_ADDR_CNT: ;
        default: next_s.pslverr = acc;
      endcase
    end
    else if (acc)
    begin
      unique case (paddr_i)
        `TFP_ADDR_FLG1:  next_s.prdata = {24'h0, s.flg1};
        `TFP_ADDR_MSK1:  next_s.prdata = {24'h0, s.msk1};
        `TFP_ADDR_MSK2:  next_s.prdata = {24'h0, s.msk2 & `TFP_MSK2_MASK};
        `TFP_ADDR_FLG2:  next_s.prdata = {24'h0, s.flg2 & `TFP_FLG2_MASK};
        `TFP_ADDR_ACCUMULATOR_PERIODIC_CONTROL: next_s.prdata = {24'h0, s.accumulator_periodic_control};
        `TFP_ADDR_CNT:   next_s.prdata = {16'h0, s.cnt};
        default:
        begin
          next_s.prdata  = 32'h0;
          next_s.pslverr = 1'b1;
        end
      endcase
    end
    // mask pairs gate the request
    next_s.irq = |(next_s.flg1 & next_s.msk1) |
                 |(next_s.flg2 & next_s.msk2 & `TFP_FLG2_MASK);
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign prdata_o  = s.prdata;
  assign pready_o  = s.pready;
  assign pslverr_o = s.pslverr;
  assign irq_o     = s.irq;
  assign counter_o = s.cnt;
  assign capture_compare_select_o = s.accumulator_periodic_control[`TFP_BIT_SEL];

  a_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && paddr_i == `TFP_ADDR_FLG2 && wd[`TFP_BIT_RTI] && !rti_to)
    |=> !s.flg2[`TFP_BIT_RTI]) else $error("periodic flag not cleared");
  a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    events_i.cmp_match[4] |=> s.flg1[7]) else $error("compare set lost");
  a_zero_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (s.flg1[0] && !(wr && paddr_i == `TFP_ADDR_FLG1 && wd[0])) |=> s.flg1[0])
    else $error("flag lost without clear");
  a_wrap_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick && s.cnt == 16'hffff) |=> (s.cnt == 16'h0 && s.flg2[`TFP_BIT_OVF]))
    else $error("overflow flag missing");
  a_irq_pair: assert property (@(posedge clk_i) disable iff (rst_i)
    (s.flg2[`TFP_BIT_OVF] && s.msk2[`TFP_BIT_OVF]) |-> s.irq)
    else $error("overflow irq missing");
  a_flg2_low: assert property (@(posedge clk_i) disable iff (rst_i)
    s.flg2[3:0] == 4'h0) else $error("low flag bits set");
  a_pr_lock: assert property (@(posedge clk_i) disable iff (rst_i)
    (normal_mode_i && s.pr_done) |=> $stable(s.msk2[1:0]))
    else $error("prescale changed twice");
  // every periodic timeout lands in the periodic flag
  a_rti_set: assert property (@(posedge clk_i) disable iff (rst_i)
    rti_to |=> s.flg2[`TFP_BIT_RTI]) else $error("periodic flag not set");

  // the periodic chain advances by one on every clock, whatever software does
  a_rti_free: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> (s.rti == $past(s.rti) + 16'h1)) else $error("periodic chain stalled");

  // two timeouts never follow back to back, the period is counted out
  a_rti_gap: assert property (@(posedge clk_i) disable iff (rst_i)
    rti_to |=> !rti_to) else $error("periodic timeout repeated");

  // the periodic flag only rises after a timeout of the chain
  a_rti_source: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(s.flg2[`TFP_BIT_RTI]) |-> $past(rti_to)) else $error("periodic flag rose early");

  // a raised periodic flag with its enable requests the interrupt
  a_rti_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    (s.flg2[`TFP_BIT_RTI] && s.msk2[`TFP_BIT_RTI]) |-> s.irq)
    else $error("periodic irq missing");

  // counter moves by exactly one on each prescaler tick
  a_cnt_tick: assert property (@(posedge clk_i) disable iff (rst_i)
    tick |=> (s.cnt == $past(s.cnt) + 16'h1)) else $error("counter missed a tick");

  // counter holds between prescaler ticks
  a_cnt_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !tick |=> $stable(s.cnt)) else $error("counter moved without tick");

  // the overflow flag only rises from a wrap of the counter
  a_ovf_source: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(s.flg2[`TFP_BIT_OVF]) |-> ($past(s.cnt) == 16'hffff && s.cnt == 16'h0))
    else $error("overflow flag without wrap");

  // capture edge on a channel sets its capture flag
  a_cap_set: assert property (@(posedge clk_i) disable iff (rst_i)
    events_i.cap_edge[0] |=> s.flg1[0]) else $error("capture flag missing");

  // shared flag follows compare when the compare function is selected
  a_shared_cmp: assert property (@(posedge clk_i) disable iff (rst_i)
    (!s.accumulator_periodic_control[`TFP_BIT_SEL] && events_i.cmp_match[0]) |=> s.flg1[`TFP_BIT_SEL + 1])
    else $error("shared compare flag missing");

  // shared flag follows capture when the capture function is selected
  a_shared_cap: assert property (@(posedge clk_i) disable iff (rst_i)
    (s.accumulator_periodic_control[`TFP_BIT_SEL] && events_i.cap4_edge) |=> s.flg1[`TFP_BIT_SEL + 1])
    else $error("shared capture flag missing");

  // compare match on the second channel sets its flag
  a_cmp_set: assert property (@(posedge clk_i) disable iff (rst_i)
    events_i.cmp_match[1] |=> s.flg1[4]) else $error("compare flag missing");

  // accumulator rollover sets its flag
  a_acc_roll: assert property (@(posedge clk_i) disable iff (rst_i)
    events_i.acc_roll |=> s.flg2[`TFP_BIT_PAOV]) else $error("rollover flag missing");

  // accumulator input edge sets its flag
  a_acc_edge: assert property (@(posedge clk_i) disable iff (rst_i)
    events_i.acc_edge |=> s.flg2[`TFP_BIT_PAI]) else $error("edge flag missing");

  // a first-register flag with its mask raises the request
  a_pair_one: assert property (@(posedge clk_i) disable iff (rst_i)
    (s.flg1[0] && s.msk1[0]) |-> s.irq) else $error("first pair irq missing");

  // with no flag and mask pair set the request is released
  a_irq_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    (!(|(s.flg1 & s.msk1)) && !(|(s.flg2 & s.msk2 & `TFP_FLG2_MASK))) |-> !s.irq)
    else $error("irq without source");

  // reads of the second flag register show zero in the low nibble
  a_flg2_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (acc && !pwrite_i && paddr_i == `TFP_ADDR_FLG2) |=> (s.prdata[3:0] == 4'h0))
    else $error("flag low bits read back");

  // reads of the second mask register show zero in bits 3 and 2
  a_msk2_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (acc && !pwrite_i && paddr_i == `TFP_ADDR_MSK2) |=> (s.prdata[3:2] == 2'h0))
    else $error("mask unused bits read back");

  // an access always gets its ready one cycle later
  a_ready_once: assert property (@(posedge clk_i) disable iff (rst_i)
    acc |=> s.pready) else $error("ready missing");

  // ready is a single-cycle pulse
  a_ready_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    s.pready |=> !s.pready) else $error("ready stuck high");

  // the prescale field locks once the early window is over
  a_pr_window: assert property (@(posedge clk_i) disable iff (rst_i)
    (normal_mode_i && s.age == `TFP_PR_WINDOW) |=> $stable(s.msk2[1:0]))
    else $error("prescale changed late");
  a_rti_period: assert property (@(posedge clk_i) disable iff (rst_i)
    (s.rti < 16'h1fff) |-> !set2[`TFP_BIT_RTI]) else $error("early timeout");
endmodule

//--- bench/timer_flags_prescaler_rti_tb.sv
// self-checking bench for the timer flag, prescaler and periodic block
`timescale 1ns/100ps
`include "tfp_cfg.svh"
module timer_flags_prescaler_rti_tb
  import tfp_pkg::*;
;
  logic        clk_i     = 1'b0;
  logic        rst_i     = 1'b1;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [11:0] paddr_i   = 12'h000;
  logic [31:0] pwdata_i  = 32'h0;
  tfp_events_t events_i  = '0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        irq_o;
  logic [15:0] cnt_o;
  logic        sel_o;
  logic [33:0] notes[$];
  logic [33:0] note;
  int          fail_count  = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  integer      seed        = 32'hbe16709b;
  logic [31:0] r;

  tfp_timer_flags dut (
    .clk_i                    (clk_i),
    .rst_i                    (rst_i),
    .psel_i                   (psel_i),
    .penable_i                (penable_i),
    .pwrite_i                 (pwrite_i),
    .paddr_i                  (paddr_i),
    .pwdata_i                 (pwdata_i),
    .events_i                 (events_i),
    .normal_mode_i            (1'b1),
    .prdata_o                 (prdata_o),
    .pready_o                 (pready_o),
    .pslverr_o                (pslverr_o),
    .irq_o                    (irq_o),
    .counter_o                (cnt_o),
    .capture_compare_select_o (sel_o)
  );

  // 125 mhz clock
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end

  task close_out;
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task bad(input logic [33:0] got, input logic [33:0] exp);
    fail_count++;
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
  endtask

  // one apb transfer; the note {check data, error, data} is queued first
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
    notes.push_back(e);
    @(posedge clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {2'b10, e});
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 34'h0);
  endtask

  task pulse(input tfp_events_t v);
    @(posedge clk_i);
    events_i <= v;
    @(posedge clk_i);
    events_i <= '0;
  endtask

  task irq_is(input logic e);
    repeat (3) @(posedge clk_i);
    comparisons++;
    if (irq_o !== e) bad({33'h0, irq_o}, {33'h0, e});
  endtask

  // counter steps once per clock with prescale code 00
  task cnt_step;
    logic [15:0] a;
    @(posedge clk_i);
    a = cnt_o;
    @(posedge clk_i);
    comparisons++;
    if (cnt_o !== a + 16'h1) bad({18'h0, cnt_o}, {18'h0, a + 16'h1});
  endtask

  // cut a hang short
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      fail_count++;
      close_out;
    end
  end

  // compare each answer with the oldest note
  always @(posedge clk_i)
  begin
    if (pready_o === 1'b1)
    begin
      note = notes.pop_front();
      comparisons++;
      if (pslverr_o !== note[32] || (note[33] && prdata_o !== note[31:0]))
        bad({1'b0, pslverr_o, prdata_o}, note);
    end
  end

  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wr(`TFP_ADDR_MSK2, 32'hfc);
    rd(`TFP_ADDR_MSK2, 32'hf0);
    wr(`TFP_ADDR_MSK2, 32'h03);
    rd(`TFP_ADDR_MSK2, 32'h00);
    rd(`TFP_ADDR_FLG2, 32'h00);
    wr(`TFP_ADDR_ACCUMULATOR_PERIODIC_CONTROL, 32'h04);
    comparisons++;
    if (sel_o !== 1'b1) bad({33'h0, sel_o}, 34'h1);
    cnt_step;
    pulse(11'h7f8);
    rd(`TFP_ADDR_FLG1, 32'hf7);
    wr(`TFP_ADDR_FLG1, 32'hff);
    wr(`TFP_ADDR_ACCUMULATOR_PERIODIC_CONTROL, 32'h00);
    pulse(11'h004);
    rd(`TFP_ADDR_FLG1, 32'h00);
    pulse(11'h7c0);
    rd(`TFP_ADDR_FLG1, 32'hf8);
    r = $random(seed);
    wr(`TFP_ADDR_FLG1, r);
    rd(`TFP_ADDR_FLG1, {24'h0, 8'hf8 & ~r[7:0]});
    wr(`TFP_ADDR_MSK1, 32'hff);
    irq_is(|(8'hf8 & ~r[7:0]));
    wr(`TFP_ADDR_FLG1, 32'hff);
    irq_is(1'b0);
    pulse(11'h003);
    rd(`TFP_ADDR_FLG2, 32'h30);
    wr(`TFP_ADDR_FLG2, 32'h30);
    rd(`TFP_ADDR_FLG2, 32'h00);
    apb(1'b0, 12'h018, 32'h0, {2'b01, 32'h0});
    repeat (68000) @(posedge clk_i);
    rd(`TFP_ADDR_FLG2, 32'hc0);
    wr(`TFP_ADDR_FLG2, 32'h40);
    rd(`TFP_ADDR_FLG2, 32'h80);
    wr(`TFP_ADDR_MSK2, 32'h80);
    irq_is(1'b1);
    wr(`TFP_ADDR_FLG2, 32'h80);
    irq_is(1'b0);
    close_out;
  end
endmodule
